// >>> core/ncto_pkg.sv
package ncto_pkg;
	// ***********************************************************
	// widths
	// ***********************************************************
	localparam int BANK_W  = 2;
	localparam int ROW_W   = 3;
	localparam int COL_W   = 4;
	localparam int NIB_W   = 4;
	localparam int DADDR_W = BANK_W + ROW_W + COL_W;
	localparam int PWORD_W = 16;
	localparam int SP_W    = 3;
	localparam int HADDR_W = 8;

	// ***********************************************************
	// opcode fields
	// ***********************************************************
	localparam logic [4:0] OP_ST_IND  = 5'h0a;
	localparam logic [4:0] OP_LD_IND  = 5'h0b;
	localparam logic [4:0] OP_MOV_IMM = 5'h1d;
	localparam logic [4:0] OP_SYSTEM  = 5'h07;
	localparam logic [2:0] SYS_ROW    = 3'h0;
	localparam logic [3:0] SYS_TABLE_READ_INSTR   = 4'h1;
	localparam logic [3:0] SYS_PUSH   = 4'hd;
	localparam logic [3:0] SYS_POP    = 4'hc;
	localparam logic [3:0] SYS_LOW    = 4'h0;

	// ***********************************************************
	// register offsets and fields
	// ***********************************************************
	localparam logic [7:0] A_INSTR  = 8'h00;
	localparam logic [7:0] A_CTRL   = 8'h04;
	localparam logic [7:0] A_INDEX  = 8'h08;
	localparam logic [7:0] A_TADDR  = 8'h0c;
	localparam logic [7:0] A_DBUF   = 8'h10;
	localparam logic [7:0] A_STACK  = 8'h14;
	localparam logic [7:0] A_PC     = 8'h18;
	localparam logic [7:0] A_STATUS = 8'h1c;
	localparam logic [7:0] A_WIN    = 8'h20;
	localparam logic [7:0] A_WDATA  = 8'h24;
	localparam int CF_PTR_EN = 0;
	localparam int CF_IDX_EN = 1;
	localparam int CF_BANK   = 4;
	localparam int CF_RPH    = 8;
	localparam int CF_RPL    = 12;
	localparam int CF_MPL    = 16;
	localparam int CF_MPH    = 20;
	localparam logic [PWORD_W-1:0] RST_WORD = 16'h0000;
	localparam logic [SP_W-1:0]    RST_SP   = 3'h0;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_GREG  = 3'b001,
		S_SRC   = 3'b011,
		S_WRITE = 3'b010,
		S_TADDR = 3'b110,
		S_TWAIT = 3'b111,
		S_TCAP  = 3'b101,
		S_STACK = 3'b100
	} ncto_state_t;

	function automatic logic [DADDR_W-1:0] ncto_daddr(
		input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r,
		input logic [COL_W-1:0] c);
		return {b, r, c};
	endfunction

	function automatic logic [DADDR_W-1:0] ncto_eff(
		input logic [DADDR_W-1:0] m, input logic index_enable_flag,
		input logic [DADDR_W-1:0] ix);
		return index_enable_flag ? (m | ix) : m;
	endfunction

	function automatic logic ncto_sys(input logic [15:0] w,
		input logic [3:0] sub);
		return w[15:11] == OP_SYSTEM && w[10:8] == SYS_ROW &&
			w[7:4] == sub && w[3:0] == SYS_LOW;
	endfunction
endpackage

// >>> core/ncto_dmem_if.sv
`timescale 1ns/1ps
interface ncto_dmem_if;
	import ncto_pkg::*;
	logic [DADDR_W-1:0] exe_raddr;
	logic [NIB_W-1:0]   exe_rdata;
	logic [DADDR_W-1:0] bus_raddr;
	logic [NIB_W-1:0]   bus_rdata;
	logic               we;
	logic [DADDR_W-1:0] waddr;
	logic [NIB_W-1:0]   wdata;
	modport ctrl (output exe_raddr, bus_raddr, we, waddr, wdata,
		input exe_rdata, bus_rdata);
	modport mem (input exe_raddr, bus_raddr, we, waddr, wdata,
		output exe_rdata, bus_rdata);
endinterface

// >>> core/ncto_nibble_ram.sv
`timescale 1ns/1ps
module ncto_nibble_ram (
	input wire logic clk_sys_i,
	ncto_dmem_if.mem dm
);
	import ncto_pkg::*;
	localparam int DEPTH = 1 << DADDR_W;

	logic [NIB_W-1:0] cell_r [DEPTH];

	assign dm.exe_rdata = cell_r[dm.exe_raddr];
	assign dm.bus_rdata = cell_r[dm.bus_raddr];

	always_ff @(posedge clk_sys_i) begin
		if (dm.we) begin
			cell_r[dm.waddr] <= dm.wdata;
		end
	end
endmodule

// >>> core/ncto_transfer_ops.sv
`timescale 1ns/1ps
module ncto_transfer_ops #(
	parameter int STACK_AW = ncto_pkg::SP_W
) (
	input  wire logic                         clk_sys_i,
	input  wire logic                         rst_i,
	input  wire logic                         hsel_i,
	input  wire logic [31:0]                  haddr_i,
	input  wire logic [1:0]                   htrans_i,
	input  wire logic                         hwrite_i,
	input  wire logic [2:0]                   hsize_i,
	input  wire logic [31:0]                  hwdata_i,
	input  wire logic                         hready_i,
	output logic      [31:0]                  hrdata_o,
	output logic                              hreadyout_o,
	output logic                              hresp_o,
	output logic      [ncto_pkg::PWORD_W-1:0] prog_addr_o,
	output logic                              prog_rd_o,
	input  wire logic [ncto_pkg::PWORD_W-1:0] prog_data_i,
	output logic                              busy_o
);
	import ncto_pkg::*;
	localparam int SLOTS = 1 << STACK_AW;

	// ***********************************************************
	// storage
	// ***********************************************************
	ncto_dmem_if dm ();
	ncto_nibble_ram u_ram (
		.clk_sys_i (clk_sys_i),
		.dm        (dm)
	);

	ncto_state_t         state_r;
	ncto_state_t         state_nxt;
	logic [15:0]         instr_r;
	logic [NIB_W-1:0]    gcol_r;
	logic [NIB_W-1:0]    val_r;
	logic                ptr_en_r;
	logic                idx_en_r;
	logic [BANK_W-1:0]   bank_r;
	logic [BANK_W-1:0]   rph_r;
	logic [ROW_W-1:0]    rpl_r;
	logic [BANK_W-1:0]   mph_r;
	logic [ROW_W-1:0]    mpl_r;
	logic [DADDR_W-1:0]  ix_r;
	logic [DADDR_W-1:0]  win_r;
	logic [PWORD_W-1:0]  ar_r;
	logic [PWORD_W-1:0]  pc_r;
	logic [PWORD_W-1:0]  dbf_r;
	logic [STACK_AW-1:0] sp_r;
	logic [PWORD_W-1:0]  stack_r [SLOTS];
	logic [31:0]         rd_word;
	logic                ph_wr_r;
	logic [HADDR_W-1:0]  ph_addr_r;

	// ***********************************************************
	// decode
	// ***********************************************************
	wire [4:0]          f_maj   = instr_r[15:11];
	wire [ROW_W-1:0]    f_row   = instr_r[10:8];
	wire [COL_W-1:0]    f_col   = instr_r[7:4];
	wire [NIB_W-1:0]    f_low   = instr_r[3:0];
	wire                is_st   = f_maj == OP_ST_IND;
	wire                is_ld   = f_maj == OP_LD_IND;
	wire                is_imm  = f_maj == OP_MOV_IMM;
	wire                is_push = ncto_sys(instr_r, SYS_PUSH);
	wire                is_pop  = ncto_sys(instr_r, SYS_POP);
	wire [DADDR_W-1:0]  m_base  = ncto_daddr(bank_r, f_row, f_col);
	wire [DADDR_W-1:0]  m_eff   = ncto_eff(m_base, idx_en_r, ix_r);
	wire [DADDR_W-1:0]  gr_addr = ncto_daddr(rph_r, rpl_r, f_low);
	wire [DADDR_W-1:0]  mp_addr = ncto_daddr(mph_r, mpl_r, gcol_r);
	wire [DADDR_W-1:0]  rw_addr = ncto_daddr(bank_r, f_row, gcol_r);
	wire [DADDR_W-1:0]  ind_addr = ptr_en_r ? mp_addr : rw_addr;
	wire [DADDR_W-1:0]  src_addr = is_ld ? ind_addr : m_eff;
	wire [DADDR_W-1:0]  dst_addr = is_st ? ind_addr : m_eff;
	wire [STACK_AW-1:0] sp_dec  = sp_r - STACK_AW'(1);
	wire [STACK_AW-1:0] sp_inc  = sp_r + STACK_AW'(1);
	wire [PWORD_W-1:0]  top_slot = stack_r[sp_r];

	// ***********************************************************
	// bus decode
	// ***********************************************************
	wire addr_ok  = hsel_i & hready_i & htrans_i[1];
	wire bus_wr   = ph_wr_r & (state_r == S_IDLE);
	wire launch   = bus_wr & (ph_addr_r == A_INSTR);
	wire wr_ctrl  = bus_wr & (ph_addr_r == A_CTRL);
	wire wr_mem   = bus_wr & (ph_addr_r == A_WDATA);
	wire fsm_we   = state_r == S_WRITE;

	assign dm.exe_raddr = (state_r == S_GREG) ? gr_addr : src_addr;
	assign dm.bus_raddr = win_r;
	assign dm.we        = fsm_we | wr_mem;
	assign dm.waddr     = fsm_we ? dst_addr : win_r;
	assign dm.wdata     = fsm_we ? (is_imm ? f_low : val_r)
		: hwdata_i[NIB_W-1:0];

	function automatic ncto_state_t first_state(input logic [15:0] w);
		if (w[15:11] == OP_ST_IND || w[15:11] == OP_LD_IND) begin
			return S_GREG;
		end else if (w[15:11] == OP_MOV_IMM) begin
			return S_WRITE;
		end else if (ncto_sys(w, SYS_TABLE_READ_INSTR)) begin
			return S_TADDR;
		end else if (ncto_sys(w, SYS_PUSH) || ncto_sys(w, SYS_POP)) begin
			return S_STACK;
		end
		return S_IDLE;
	endfunction

	// ***********************************************************
	// sequencer
	// ***********************************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
		S_IDLE: begin
			if (launch) begin
				state_nxt = first_state(hwdata_i[15:0]);
			end
		end
		S_GREG:  state_nxt = S_SRC;
		S_SRC:   state_nxt = S_WRITE;
		S_TADDR: state_nxt = S_TWAIT;
		S_TWAIT: state_nxt = S_TCAP;
		default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= S_IDLE;
			busy_o  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			busy_o  <= state_nxt != S_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			instr_r <= RST_WORD;
			gcol_r  <= '0;
			val_r   <= '0;
		end else begin
			if (launch) begin
				instr_r <= hwdata_i[15:0];
			end
			if (state_r == S_GREG) begin
				gcol_r <= dm.exe_rdata;
			end
			if (state_r == S_SRC) begin
				val_r <= dm.exe_rdata;
			end
		end
	end

	// table read and stack handling
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sp_r        <= RST_SP;
			pc_r        <= RST_WORD;
			ar_r        <= RST_WORD;
			dbf_r       <= RST_WORD;
			prog_addr_o <= RST_WORD;
			prog_rd_o   <= 1'b0;
			for (int i = 0; i < SLOTS; i++) begin
				stack_r[i] <= RST_WORD;
			end
		end else begin
			prog_rd_o <= state_r == S_TADDR;
			if (bus_wr && ph_addr_r == A_TADDR) begin
				ar_r <= hwdata_i[PWORD_W-1:0];
			end
			if (bus_wr && ph_addr_r == A_PC) begin
				pc_r <= hwdata_i[PWORD_W-1:0];
			end
			case (state_r)
			S_TADDR: begin
				sp_r            <= sp_dec;
				stack_r[sp_dec] <= pc_r;
				pc_r            <= ar_r;
				prog_addr_o     <= ar_r;
			end
			S_TCAP: begin
				dbf_r <= prog_data_i;
				pc_r  <= top_slot;
				sp_r  <= sp_inc;
			end
			S_STACK: begin
				if (is_push) begin
					sp_r            <= sp_dec;
					stack_r[sp_dec] <= ar_r;
				end else if (is_pop) begin
					ar_r <= top_slot;
					sp_r <= sp_inc;
				end
			end
			default: begin
			end
			endcase
		end
	end

	// ***********************************************************
	// register file on the bus
	// ***********************************************************
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ptr_en_r <= 1'b0;
			idx_en_r <= 1'b0;
			bank_r   <= '0;
			rph_r    <= '0;
			rpl_r    <= '0;
			mph_r    <= '0;
			mpl_r    <= '0;
			ix_r     <= '0;
			win_r    <= '0;
		end else begin
			if (wr_ctrl) begin
				ptr_en_r <= hwdata_i[CF_PTR_EN];
				idx_en_r <= hwdata_i[CF_IDX_EN];
				bank_r   <= hwdata_i[CF_BANK +: BANK_W];
				rph_r    <= hwdata_i[CF_RPH +: BANK_W];
				rpl_r    <= hwdata_i[CF_RPL +: ROW_W];
				mph_r    <= hwdata_i[CF_MPH +: BANK_W];
				mpl_r    <= hwdata_i[CF_MPL +: ROW_W];
			end
			if (bus_wr && ph_addr_r == A_INDEX) begin
				ix_r <= hwdata_i[DADDR_W-1:0];
			end
			if (bus_wr && ph_addr_r == A_WIN) begin
				win_r <= hwdata_i[DADDR_W-1:0];
			end
		end
	end

	always_comb begin
		rd_word = '0;
		case (haddr_i[HADDR_W-1:0])
		A_INSTR:  rd_word[15:0] = instr_r;
		A_CTRL: begin
			rd_word[CF_PTR_EN]           = ptr_en_r;
			rd_word[CF_IDX_EN]           = idx_en_r;
			rd_word[CF_BANK +: BANK_W]   = bank_r;
			rd_word[CF_RPH +: BANK_W]    = rph_r;
			rd_word[CF_RPL +: ROW_W]     = rpl_r;
			rd_word[CF_MPH +: BANK_W]    = mph_r;
			rd_word[CF_MPL +: ROW_W]     = mpl_r;
		end
		A_INDEX:  rd_word[DADDR_W-1:0]  = ix_r;
		A_TADDR:  rd_word[PWORD_W-1:0]  = ar_r;
		A_DBUF:   rd_word[PWORD_W-1:0]  = dbf_r;
		A_STACK:  rd_word[STACK_AW-1:0] = sp_r;
		A_PC:     rd_word[PWORD_W-1:0]  = pc_r;
		A_STATUS: rd_word[0]            = busy_o;
		A_WIN:    rd_word[DADDR_W-1:0]  = win_r;
		A_WDATA:  rd_word[NIB_W-1:0]    = dm.bus_rdata;
		default:  rd_word = '0;
		endcase
	end

	// zero-wait slave: read data is latched in the address phase
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ph_wr_r     <= 1'b0;
			ph_addr_r   <= '0;
			hrdata_o    <= '0;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			ph_wr_r <= addr_ok & hwrite_i;
			if (addr_ok) begin
				ph_addr_r <= haddr_i[HADDR_W-1:0];
			end
			if (addr_ok && !hwrite_i) begin
				hrdata_o <= rd_word;
			end
		end
	end

	// ***********************************************************
	// checks
	// ***********************************************************
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	chk_st_ptr_dest: assert property (
		state_r == S_GREG && is_st && ptr_en_r |-> ##2
		(dm.we && dm.waddr == {mph_r, mpl_r, $past(dm.exe_rdata, 2)}))
		else $error("indirect store ignored pointer row");
	chk_ld_ptr_src: assert property (
		state_r == S_GREG && is_ld && ptr_en_r |=>
		dm.exe_raddr == {mph_r, mpl_r, $past(dm.exe_rdata)})
		else $error("indirect load ignored pointer row");
	chk_ind_same_row: assert property (
		state_r == S_GREG && (is_st || is_ld) && !ptr_en_r |=>
		ind_addr == {bank_r, f_row, $past(dm.exe_rdata)})
		else $error("indirect move left current row");
	chk_st_copy_data: assert property (
		state_r == S_SRC && is_st |=>
		dm.we && dm.wdata == $past(dm.exe_rdata))
		else $error("indirect store wrote wrong data");
	chk_ld_copy_dest: assert property (
		state_r == S_SRC && is_ld |=> dm.we && dm.waddr == m_eff &&
		dm.wdata == $past(dm.exe_rdata))
		else $error("indirect load wrote wrong place");
	chk_imm_decode: assert property (
		launch && hwdata_i[15:11] == OP_MOV_IMM |=>
		state_r == S_WRITE ##1 state_r == S_IDLE)
		else $error("immediate move not decoded");
	chk_imm_value: assert property (
		state_r == S_WRITE && is_imm |-> dm.we &&
		dm.wdata == instr_r[3:0])
		else $error("immediate value not written");
	chk_table_read_instr_fetch: assert property (
		launch && ncto_sys(hwdata_i[15:0], SYS_TABLE_READ_INSTR) |=>
		state_r == S_TADDR ##1 (prog_rd_o && prog_addr_o == ar_r))
		else $error("table read fetched wrong address");
	chk_table_read_instr_stack: assert property (
		state_r == S_TADDR |=> sp_r == $past(sp_dec) ##2
		(sp_r == $past(sp_r, 3) && pc_r == $past(pc_r, 3)))
		else $error("table read did not restore stack");
	chk_dbuf_order: assert property (
		state_r == S_TCAP |=> dbf_r == $past(prog_data_i))
		else $error("buffer nibbles misplaced");
	chk_push_slot: assert property (
		state_r == S_STACK && is_push |=>
		sp_r == $past(sp_dec) && top_slot == $past(ar_r))
		else $error("push stored wrong slot");
	chk_pop_load: assert property (
		state_r == S_STACK && is_pop |=>
		ar_r == $past(top_slot) && sp_r == $past(sp_inc))
		else $error("pop loaded wrong slot");
	chk_index_or: assert property (
		state_r == S_WRITE && is_imm && idx_en_r |->
		(dm.waddr & ix_r) == ix_r)
		else $error("index not merged into address");

	cov_table_read: cover property (state_r == S_TCAP);
	cov_push_pop: cover property (
		state_r == S_STACK && is_push ##[1:40] state_r == S_STACK && is_pop);
	cov_ind_ptr: cover property (state_r == S_WRITE && is_st && ptr_en_r);
	cov_imm_idx: cover property (state_r == S_WRITE && is_imm && idx_en_r);
endmodule

// >>> sim/nibble_cpu_transfer_ops_tb.sv
`timescale 1ns/1ps
module nibble_cpu_transfer_ops_tb;
	import ncto_pkg::*;
	logic               clk_sys_i;
	logic               rst_i;
	logic               hsel_i;
	logic [31:0]        haddr_i;
	logic [1:0]         htrans_i;
	logic               hwrite_i;
	logic [31:0]        hwdata_i;
	logic [31:0]        hrdata_o;
	logic               hreadyout_o;
	logic               hresp_o;
	logic [15:0]        prog_addr_o;
	logic               prog_rd_o;
	logic [15:0]        prog_data_i;
	logic               busy_o;
	logic               rd_ph;
	logic [31:0]        exp_q[$];
	int                 err_count;
	int                 check_count;
	int                 cyc;
	logic [1:0]         bk;
	logic [1:0]         pointer_row_high;
	logic [2:0]         mr;
	logic [2:0]         pointer_row_low;
	logic [3:0]         mc;
	logic [3:0]         c;
	logic [3:0]         rn;
	logic [3:0]         v1;
	logic [8:0]         m;
	logic [8:0]         ia;
	logic [8:0]         ix;
	logic [15:0]        ta;
	logic [15:0]        pc;
	logic [15:0]        t[8];
	logic [7:0]         ra[8];
	logic               ld;
	logic               pe;
	logic [15:0]        table_read_instr_w;

	ncto_transfer_ops DUT (
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.hsel_i      (hsel_i),
		.haddr_i     (haddr_i),
		.htrans_i    (htrans_i),
		.hwrite_i    (hwrite_i),
		.hsize_i     (3'h2),
		.hwdata_i    (hwdata_i),
		.hready_i    (hreadyout_o),
		.hrdata_o    (hrdata_o),
		.hreadyout_o (hreadyout_o),
		.hresp_o     (hresp_o),
		.prog_addr_o (prog_addr_o),
		.prog_rd_o   (prog_rd_o),
		.prog_data_i (prog_data_i),
		.busy_o      (busy_o)
	);

	// ***********************************************************
	// clock, program memory, monitor, timeout
	// ***********************************************************
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [15:0] pm(input logic [15:0] a);
		return (a == 16'h0011) ? 16'habcd : {a[7:0], ~a[15:8]};
	endfunction

	// one cycle latency; word toggles when not addressed
	always @(posedge clk_sys_i) begin
		prog_data_i <= prog_rd_o ? pm(prog_addr_o) : ~prog_data_i;
	end

	always @(posedge clk_sys_i) begin
		if (rd_ph === 1'b1 && hreadyout_o === 1'b1)
			check(hrdata_o, exp_q.pop_front());
	end

	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	// ***********************************************************
	// tasks
	// ***********************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] e);
		check_count++;
		if (seen !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, e);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d, input logic [31:0] e);
		hsel_i   <= 1'b1;
		haddr_i  <= {24'h0, a};
		hwrite_i <= w;
		htrans_i <= 2'b10;
		@(posedge clk_sys_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
		htrans_i <= 2'b00;
		hwdata_i <= d;
		if (!w) begin
			exp_q.push_back(e);
			rd_ph <= 1'b1;
		end
		@(posedge clk_sys_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
		rd_ph <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d, 32'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0, e);
	endtask

	task automatic mem_wr(input logic [8:0] a, input logic [3:0] v);
		wr(A_WIN, {23'h0, a});
		wr(A_WDATA, {28'h0, v});
	endtask

	task automatic mem_rd(input logic [8:0] a, input logic [3:0] v);
		wr(A_WIN, {23'h0, a});
		rd(A_WDATA, {28'h0, v});
	endtask

	task automatic exec(input logic [15:0] w);
		wr(A_INSTR, {16'h0, w});
		@(posedge clk_sys_i);
		while (busy_o !== 1'b0) @(posedge clk_sys_i);
	endtask

	// ***********************************************************
	// main sequence
	// ***********************************************************
	initial begin
		void'($urandom(32'hceb9e3ae));
		{hsel_i, hwrite_i, rd_ph, htrans_i} = '0;
		{haddr_i, hwdata_i, cyc, err_count, check_count} = '0;
		prog_data_i = 16'h0;
		table_read_instr_w = {OP_SYSTEM, SYS_ROW, SYS_TABLE_READ_INSTR, SYS_LOW};
		ra = '{A_CTRL, A_INDEX, A_TADDR, A_DBUF, A_STACK, A_PC,
			A_STATUS, 8'h30};
		rst_i = 1'b1;
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		wr(A_DBUF, 32'h0000ffff);
		foreach (ra[i]) rd(ra[i], 32'h0);
		for (int i = 0; i < 6; i++) begin
			bk = $urandom;
			mr = $urandom;
			mc = $urandom;
			v1 = $urandom;
			ix = $urandom;
			wr(A_CTRL, {26'h0, bk, 2'h0, i[0], 1'b0});
			wr(A_INDEX, {23'h0, ix});
			m = i[0] ? ({bk, mr, mc} | ix) : {bk, mr, mc};
			exec({OP_MOV_IMM, mr, mc, v1});
			mem_rd(m, v1);
		end
		for (int i = 0; i < 8; i++) begin
			ld = i[0];
			pe = i[1];
			bk = 2'($urandom % 3);
			pointer_row_high = 2'($urandom % 3);
			mr = $urandom;
			pointer_row_low = $urandom;
			mc = $urandom;
			rn = $urandom;
			v1 = $urandom;
			c = mc ^ 4'h5;
			m = {bk, mr, mc};
			ia = pe ? {pointer_row_high, pointer_row_low, c} : {bk, mr, c};
			wr(A_CTRL, {10'h0, pointer_row_high, 1'b0, pointer_row_low, 1'b0, 3'h7, 2'h0, 2'h3,
				2'h0, bk, 3'h0, pe});
			mem_wr({2'h3, 3'h7, rn}, c);
			mem_wr(m, v1);
			mem_wr(ia, ~v1);
			exec({ld ? OP_LD_IND : OP_ST_IND, mr, mc, rn});
			if (ld)
				mem_rd(m, ~v1);
			else
				mem_rd(ia, v1);
		end
		for (int i = 0; i < 4; i++) begin
			ta = (i == 0) ? 16'h0011 : 16'($urandom);
			pc = $urandom;
			wr(A_TADDR, {16'h0, ta});
			rd(A_TADDR, {16'h0, ta});
			wr(A_PC, {16'h0, pc});
			exec(table_read_instr_w);
			rd(A_DBUF, {16'h0, pm(ta)});
			rd(A_PC, {16'h0, pc});
			rd(A_STACK, 32'h0);
		end
		for (int k = 0; k < 8; k++) begin
			t[k] = $urandom;
			wr(A_TADDR, {16'h0, t[k]});
			exec({OP_SYSTEM, SYS_ROW, SYS_PUSH, SYS_LOW});
			rd(A_STACK, 32'(7 - k));
		end
		pc = $urandom;
		wr(A_PC, {16'h0, pc});
		exec(table_read_instr_w);
		rd(A_STACK, 32'h0);
		rd(A_DBUF, {16'h0, pm(t[7])});
		for (int k = 1; k <= 8; k++) begin
			exec({OP_SYSTEM, SYS_ROW, SYS_POP, SYS_LOW});
			rd(A_TADDR, {16'h0, (k == 8) ? pc : t[8-k]});
			rd(A_STACK, 32'(k % 8));
		end
		repeat (2) @(posedge clk_sys_i);
		give_verdict();
	end
endmodule
